// ==== sfrb_defs.svh ====
// serial flash read/buffer/program sequencer: opcodes, header lengths, field positions, timing
// assumes a 100 MHz core clock; included by bare name
`ifndef SFRB_DEFS_SVH
`define SFRB_DEFS_SVH

// ****************************************
// opcodes
// ****************************************
`define SFRB_OP_ARR_RD_LF 8'h03
`define SFRB_OP_PAGE_RD 8'hD2
`define SFRB_OP_BUF_RD_HF 8'hD4
`define SFRB_OP_BUF_RD_LF 8'hD1
`define SFRB_OP_BUF_WR 8'h84
`define SFRB_OP_PROG_ERS 8'h83
`define SFRB_OP_PROG 8'h88

// ****************************************
// frame layout, in whole bytes before data
// ****************************************
`define SFRB_HDR_ARR 4'h4
`define SFRB_HDR_BUF_RD 4'h5
`define SFRB_HDR_PAGE_RD 4'h8
`define SFRB_HDR_NONE 4'hF
`define SFRB_BYTE_MAX 4'hF

// ****************************************
// address fields
// ****************************************
`define SFRB_PG264_HI 18
`define SFRB_PG264_LO 9
`define SFRB_PG256_HI 17
`define SFRB_PG256_LO 8
`define SFRB_LAST_264 9'h107
`define SFRB_LAST_256 9'h0FF
`define SFRB_BUF_DEPTH 264
`define SFRB_SYNC_RST 4'h8

// ****************************************
// timing
// ****************************************
`define SFRB_CLK_PERIOD_NS 10
`define SFRB_ERASE_AND_PROGRAM_TIME_US 20
`define SFRB_PROGRAM_ONLY_TIME_US 15
`define SFRB_ERS_PROG_CYC ((`SFRB_ERASE_AND_PROGRAM_TIME_US * 1000) / `SFRB_CLK_PERIOD_NS)
`define SFRB_PROG_CYC ((`SFRB_PROGRAM_ONLY_TIME_US * 1000) / `SFRB_CLK_PERIOD_NS)

`endif

// ==== sfrb_pkg.sv ====
// serial flash sequencer types
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package sfrb_pkg;

  typedef logic [18:0] sfrb_ptr_t;

  typedef enum {CMD_NONE, CMD_ARR_RD, CMD_PAGE_RD, CMD_BUF_RD, CMD_BUF_WR, CMD_PROG} sfrb_cmd_e;

  typedef enum {PE_IDLE, PE_ERASE, PE_COPY, PE_WAIT} sfrb_pe_e;

endpackage

`default_nettype wire

// ==== sfrb_sync.sv ====
// two-flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to i_clk; reset value is a constant
`timescale 1ns/10ps
`default_nettype none

module sfrb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] P_RST = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      meta_r <= P_RST;
      o_q <= P_RST;
    end
    else
    begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ==== sfrb_flash_seq.sv ====
// serial flash command sequencer: array/page/buffer reads, buffer write, buffer-to-page program
// assumes a host on cs/sck/si/so and a main array port with one-cycle read latency
// How it works
// - opcode 03H plus three address bytes starts array data with no dummy byte.
// - 264-byte pages: top 10 of 19 address bits page, low 9 byte.
// - 256-byte pages: 18-bit address, upper 10 page, lower 8 byte.
// - continuous read rolls from page end into next page seamlessly.
// - after the last array byte continuous read restarts at page zero.
// - chip select rising ends any read and releases the data output.
// - array and page reads never modify the buffer.
// - D2H takes three address bytes and four ignored bytes before data.
// - page read wraps to byte zero of the same page.
// - D4H and D1H both read the buffer.
// - buffer offset is the low 9 or 8 bits of the address.
// - buffer read skips one ignored byte after the address.
// - buffer read wraps to offset zero past the end.
// - 84H stores following bytes into the buffer from the given offset.
// - buffer write wraps to zero and continues until chip select rises.
// - 83H page number sits in the same place as for reads.
// - 83H at chip select rise erases page, then programs it, busy meanwhile.
// - 88H uses the same page layout as 83H.
// - 88H programs the page without erase, busy meanwhile.
// - a command starts at chip select fall with an eight-bit opcode.
// - everything shifts most significant bit first.
// - sampling on sck rise, output on fall: modes 0 and 3.
`timescale 1ns/10ps
`include "sfrb_defs.svh"
`default_nettype none

module sfrb_flash_seq #(
  parameter int P_FP_CYC = `SFRB_ERS_PROG_CYC,
  parameter int P_PROG_CYC = `SFRB_PROG_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // serial pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // page-size strap, high selects 256-byte pages
  input wire logic i_page_256,
  // status
  output logic o_busy,
  // main array port
  output logic o_arr_rd,
  output logic o_arr_wr,
  output logic o_arr_erase,
  output logic [18:0] o_arr_addr,
  output logic [7:0] o_arr_wdata,
  input wire logic [7:0] i_arr_rdata
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic sfrb_pkg::sfrb_cmd_e decode(input logic [7:0] op);
    case (op)
      `SFRB_OP_ARR_RD_LF: decode = sfrb_pkg::CMD_ARR_RD;
      `SFRB_OP_PAGE_RD: decode = sfrb_pkg::CMD_PAGE_RD;
      `SFRB_OP_BUF_RD_HF, `SFRB_OP_BUF_RD_LF: decode = sfrb_pkg::CMD_BUF_RD;
      `SFRB_OP_BUF_WR: decode = sfrb_pkg::CMD_BUF_WR;
      `SFRB_OP_PROG_ERS, `SFRB_OP_PROG: decode = sfrb_pkg::CMD_PROG;
      default: decode = sfrb_pkg::CMD_NONE;
    endcase
  endfunction

  function automatic logic [3:0] hdr_of(input sfrb_pkg::sfrb_cmd_e c);
    case (c)
      sfrb_pkg::CMD_ARR_RD, sfrb_pkg::CMD_BUF_WR: hdr_of = `SFRB_HDR_ARR;
      sfrb_pkg::CMD_PAGE_RD: hdr_of = `SFRB_HDR_PAGE_RD;
      sfrb_pkg::CMD_BUF_RD: hdr_of = `SFRB_HDR_BUF_RD;
      default: hdr_of = `SFRB_HDR_NONE;
    endcase
  endfunction

  // next pointer; only the continuous read carries into the page field
  function automatic sfrb_pkg::sfrb_ptr_t adv(input sfrb_pkg::sfrb_ptr_t p, input sfrb_pkg::sfrb_cmd_e c,
                                              input logic [8:0] last);
    adv = p;
    if (p[8:0] == last)
    begin
      adv[8:0] = 9'h000;
      if (c == sfrb_pkg::CMD_ARR_RD)
        adv[18:9] = p[18:9] + 10'h001;
    end
    else
      adv[8:0] = p[8:0] + 9'h001;
  endfunction

  // ****************************************
  // pin synchronisers and edge detect
  // ****************************************
  logic [3:0] sync_q;
  logic cs_s, sck_s, si_s, pg256_s;
  logic sck_d_r, cs_d_r;
  logic rise, fall, cs_rise;

  sfrb_sync #(.W(4), .P_RST(`SFRB_SYNC_RST)) sfrb_sync_i (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d({i_cs_n, i_sck, i_si, i_page_256}),
    .o_q(sync_q)
  );

  assign cs_s = sync_q[3];
  assign sck_s = sync_q[2];
  assign si_s = sync_q[1];
  assign pg256_s = sync_q[0];
  assign rise = sck_s & ~sck_d_r;
  assign fall = ~sck_s & sck_d_r;
  assign cs_rise = cs_s & ~cs_d_r;

  // ****************************************
  // serial front end
  // ****************************************
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [3:0] byte_cnt_r, byte_cnt_nxt;
  logic [7:0] in_sh_r, in_sh_nxt;
  logic [15:0] adr_sh_r, adr_sh_nxt;
  sfrb_pkg::sfrb_cmd_e cls_r, cls_nxt;
  logic ers_r, ers_nxt;
  sfrb_pkg::sfrb_ptr_t ptr_r, ptr_nxt;
  logic fetch_r, fetch_nxt;
  logic cap_r, cap_nxt;
  logic cap2_r, cap2_nxt;
  logic [7:0] data_r, data_nxt;
  logic so_nxt, so_oe_nxt;
  logic [7:0] byte_in;
  logic [23:0] full_adr;
  logic [3:0] hdr_len;
  logic [8:0] last_byte;
  logic is_read, data_ph, byte_done, ld_adr;
  logic buf_we, buf_re;
  logic [8:0] buf_wa, buf_ra;
  logic [7:0] buf_wd, buf_q_r;
  logic [7:0] buf_mem [0:`SFRB_BUF_DEPTH-1];

  assign byte_in = {in_sh_r[6:0], si_s};
  assign full_adr = {adr_sh_r, byte_in};
  assign hdr_len = hdr_of(cls_r);
  assign last_byte = pg256_s ? `SFRB_LAST_256 : `SFRB_LAST_264;
  assign is_read = (cls_r == sfrb_pkg::CMD_ARR_RD) || (cls_r == sfrb_pkg::CMD_PAGE_RD) ||
                   (cls_r == sfrb_pkg::CMD_BUF_RD);
  assign data_ph = byte_cnt_r >= hdr_len;
  assign byte_done = ~cs_s & rise & (bit_cnt_r == 3'h7);
  assign ld_adr = byte_done & (byte_cnt_r == 4'h3);

  always_comb
  begin
    bit_cnt_nxt = bit_cnt_r;
    byte_cnt_nxt = byte_cnt_r;
    in_sh_nxt = in_sh_r;
    adr_sh_nxt = adr_sh_r;
    cls_nxt = cls_r;
    ers_nxt = ers_r;
    ptr_nxt = ptr_r;
    fetch_nxt = 1'b0;
    cap_nxt = fetch_r;
    cap2_nxt = cap_r;
    data_nxt = data_r;
    so_nxt = o_so;
    so_oe_nxt = o_so_oe;
    buf_we = 1'b0;
    buf_wa = ptr_r[8:0];
    buf_wd = byte_in;
    if (cs_s)
    begin
      // deselected: next fall of cs opens a fresh frame
      bit_cnt_nxt = 3'h0;
      byte_cnt_nxt = 4'h0;
      cls_nxt = sfrb_pkg::CMD_NONE;
      so_oe_nxt = 1'b0;
    end
    else
    begin
      if (rise)
      begin
        in_sh_nxt = byte_in;
        bit_cnt_nxt = bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7)
        begin
          if (byte_cnt_r != `SFRB_BYTE_MAX)
            byte_cnt_nxt = byte_cnt_r + 4'h1;
          if (byte_cnt_r == 4'h0)
          begin
            cls_nxt = o_busy ? sfrb_pkg::CMD_NONE : decode(byte_in);
            ers_nxt = byte_in == `SFRB_OP_PROG_ERS;
          end
          if ((byte_cnt_r == 4'h1) || (byte_cnt_r == 4'h2))
            adr_sh_nxt = {adr_sh_r[7:0], byte_in};
          if (ld_adr)
          begin
            if (pg256_s)
              ptr_nxt = {full_adr[`SFRB_PG256_HI:`SFRB_PG256_LO], 1'b0, full_adr[7:0]};
            else
              ptr_nxt = full_adr[`SFRB_PG264_HI:0];
          end
          if (is_read && (byte_cnt_r >= hdr_len - 4'h1))
            fetch_nxt = 1'b1;
          if ((cls_r == sfrb_pkg::CMD_BUF_WR) && data_ph)
          begin
            buf_we = 1'b1;
            ptr_nxt = adv(ptr_r, cls_r, last_byte);
          end
        end
      end
      if (fall && is_read && data_ph)
      begin
        so_nxt = data_r[3'h7 - bit_cnt_r];
        so_oe_nxt = 1'b1;
      end
    end
    if (fetch_r)
      ptr_nxt = adv(ptr_r, cls_r, last_byte);
    if (cap2_r)
      data_nxt = (cls_r == sfrb_pkg::CMD_BUF_RD) ? buf_q_r : i_arr_rdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 4'h0;
      in_sh_r <= 8'h00;
      adr_sh_r <= 16'h0000;
      cls_r <= sfrb_pkg::CMD_NONE;
      ers_r <= 1'b0;
      ptr_r <= 19'h00000;
      fetch_r <= 1'b0;
      cap_r <= 1'b0;
      cap2_r <= 1'b0;
      data_r <= 8'h00;
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end
    else
    begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_s;
      bit_cnt_r <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      in_sh_r <= in_sh_nxt;
      adr_sh_r <= adr_sh_nxt;
      cls_r <= cls_nxt;
      ers_r <= ers_nxt;
      ptr_r <= ptr_nxt;
      fetch_r <= fetch_nxt;
      cap_r <= cap_nxt;
      cap2_r <= cap2_nxt;
      data_r <= data_nxt;
      o_so <= so_nxt;
      o_so_oe <= so_oe_nxt;
    end
  end

  // ****************************************
  // data buffer
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (buf_we && (buf_wa < 9'(`SFRB_BUF_DEPTH)))
      buf_mem[buf_wa] <= buf_wd;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      buf_q_r <= 8'h00;
    else if (buf_re)
      buf_q_r <= (buf_ra < 9'(`SFRB_BUF_DEPTH)) ? buf_mem[buf_ra] : 8'hFF;
  end

  // ****************************************
  // array port and program engine
  // ****************************************
  sfrb_pkg::sfrb_pe_e pe_r, pe_nxt;
  logic [9:0] pg_r, pg_nxt;
  logic [8:0] cp_idx_r, cp_idx_nxt, cp_idx_d_r;
  logic cp_v_r, cp_v_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic busy_nxt, prog_go;
  logic arr_rd_nxt, arr_wr_nxt, arr_erase_nxt;
  logic [18:0] arr_addr_nxt;
  logic [7:0] arr_wdata_nxt;

  assign prog_go = cs_rise && (cls_r == sfrb_pkg::CMD_PROG) && (byte_cnt_r >= `SFRB_HDR_ARR);

  always_comb
  begin
    pe_nxt = pe_r;
    pg_nxt = pg_r;
    cp_idx_nxt = cp_idx_r;
    cp_v_nxt = 1'b0;
    tmr_nxt = (tmr_r != 16'h0000) ? tmr_r - 16'h0001 : 16'h0000;
    arr_rd_nxt = 1'b0;
    arr_wr_nxt = 1'b0;
    arr_erase_nxt = 1'b0;
    arr_addr_nxt = o_arr_addr;
    arr_wdata_nxt = o_arr_wdata;
    buf_re = 1'b0;
    buf_ra = ptr_r[8:0];
    if (fetch_r)
    begin
      buf_re = cls_r == sfrb_pkg::CMD_BUF_RD;
      arr_rd_nxt = cls_r != sfrb_pkg::CMD_BUF_RD;
      arr_addr_nxt = ptr_r;
    end
    if (cp_v_r)
    begin
      arr_wr_nxt = 1'b1;
      arr_addr_nxt = {pg_r, cp_idx_d_r};
      arr_wdata_nxt = buf_q_r;
    end
    case (pe_r)
      sfrb_pkg::PE_IDLE:
      begin
        if (prog_go)
        begin
          pg_nxt = ptr_r[18:9];
          cp_idx_nxt = 9'h000;
          tmr_nxt = ers_r ? 16'(P_FP_CYC) : 16'(P_PROG_CYC);
          pe_nxt = ers_r ? sfrb_pkg::PE_ERASE : sfrb_pkg::PE_COPY;
        end
      end
      sfrb_pkg::PE_ERASE:
      begin
        arr_erase_nxt = 1'b1;
        arr_addr_nxt = {pg_r, 9'h000};
        pe_nxt = sfrb_pkg::PE_COPY;
      end
      sfrb_pkg::PE_COPY:
      begin
        buf_re = 1'b1;
        buf_ra = cp_idx_r;
        cp_v_nxt = 1'b1;
        if (cp_idx_r == last_byte)
          pe_nxt = sfrb_pkg::PE_WAIT;
        else
          cp_idx_nxt = cp_idx_r + 9'h001;
      end
      sfrb_pkg::PE_WAIT:
      begin
        if ((tmr_r == 16'h0000) && !cp_v_r)
          pe_nxt = sfrb_pkg::PE_IDLE;
      end
      default: pe_nxt = sfrb_pkg::PE_IDLE;
    endcase
    busy_nxt = pe_nxt != sfrb_pkg::PE_IDLE;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      pe_r <= sfrb_pkg::PE_IDLE;
      pg_r <= 10'h000;
      cp_idx_r <= 9'h000;
      cp_idx_d_r <= 9'h000;
      cp_v_r <= 1'b0;
      tmr_r <= 16'h0000;
      o_busy <= 1'b0;
      o_arr_rd <= 1'b0;
      o_arr_wr <= 1'b0;
      o_arr_erase <= 1'b0;
      o_arr_addr <= 19'h00000;
      o_arr_wdata <= 8'h00;
    end
    else
    begin
      pe_r <= pe_nxt;
      pg_r <= pg_nxt;
      cp_idx_r <= cp_idx_nxt;
      cp_idx_d_r <= cp_idx_r;
      cp_v_r <= cp_v_nxt;
      tmr_r <= tmr_nxt;
      o_busy <= busy_nxt;
      o_arr_rd <= arr_rd_nxt;
      o_arr_wr <= arr_wr_nxt;
      o_arr_erase <= arr_erase_nxt;
      o_arr_addr <= arr_addr_nxt;
      o_arr_wdata <= arr_wdata_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  chk_so_release: assert property ($rose(cs_s) |=> !o_so_oe)
    else $error("data output still driven after deselect");
  chk_buf_read_only: assert property (buf_we |-> cls_r == sfrb_pkg::CMD_BUF_WR)
    else $error("buffer written outside a buffer write");
  chk_unknown_ignored: assert property (cls_r == sfrb_pkg::CMD_NONE |=> !o_arr_rd && !buf_we)
    else $error("ignored command touched the array or buffer");
  chk_first_bit_slot: assert property ($rose(o_so_oe) |-> byte_cnt_r == hdr_len && bit_cnt_r == 3'h0)
    else $error("first data bit at wrong header position");
  chk_cont_page_roll: assert property (fetch_r && cls_r == sfrb_pkg::CMD_ARR_RD && ptr_r[8:0] == last_byte
    |=> ptr_r[8:0] == 9'h000 && ptr_r[18:9] == 10'($past(ptr_r[18:9]) + 10'h001))
    else $error("continuous read did not roll to next page");
  chk_page_rd_wrap: assert property (fetch_r && cls_r == sfrb_pkg::CMD_PAGE_RD && ptr_r[8:0] == last_byte
    |=> ptr_r == {$past(ptr_r[18:9]), 9'h000})
    else $error("page read left its page");
  chk_buf_wrap: assert property ((buf_we || (fetch_r && cls_r == sfrb_pkg::CMD_BUF_RD)) && ptr_r[8:0] == last_byte
    |=> ptr_r[8:0] == 9'h000)
    else $error("buffer offset did not wrap to zero");
  chk_addr_split_264: assert property (ld_adr && !pg256_s |=> ptr_r == $past(full_adr[18:0]))
    else $error("264-byte address split wrong");
  chk_addr_split_256: assert property (ld_adr && pg256_s
    |=> ptr_r[18:9] == $past(full_adr[17:8]) && ptr_r[8:0] == {1'b0, $past(full_adr[7:0])})
    else $error("256-byte address split wrong");
  chk_prog_busy: assert property (prog_go && !o_busy |=> o_busy)
    else $error("busy not raised at program start");
  chk_erase_first: assert property (prog_go && ers_r && !o_busy |-> ##2 o_arr_erase ##1 (!o_arr_erase)[*2])
    else $error("erase pulse not issued before programming");
  chk_no_erase_88: assert property (o_arr_erase |-> ers_r)
    else $error("erase issued for program without erase");

  cov_array_roll: cover property (fetch_r && cls_r == sfrb_pkg::CMD_ARR_RD && ptr_r[8:0] == last_byte);
  cov_buf_write: cover property (buf_we ##[1:200] buf_we);
  cov_prog_done: cover property ($fell(o_busy) && ers_r);

endmodule

`default_nettype wire

// ==== sfrb_arr_model.sv ====
// main array model behind the sequencer's array port
// assumes one-cycle read latency on the core clock; unwritten bytes follow a fixed fill pattern
`timescale 1ns/10ps
`default_nettype none

module sfrb_arr_model (
  // clock
  input wire logic i_clk,
  // array port
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_erase,
  input wire logic [18:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [logic [18:0]];

  // upper half of the array starts erased
  function automatic logic [7:0] fill(input logic [18:0] a);
    return a[18] ? 8'hFF : (a[7:0] ^ a[16:9]);
  endfunction

  initial o_rdata = 8'h00;

  always @(posedge i_clk)
  begin
    // data valid only in the cycle after a read
    if (i_rd)
      o_rdata <= mem.exists(i_addr) ? mem[i_addr] : fill(i_addr);
    else
      o_rdata <= ~o_rdata;
    if (i_erase)
      for (int i = 0; i < 512; i++)
        mem[{i_addr[18:9], i[8:0]}] = 8'hFF;
    // programming only clears bits
    if (i_wr)
      mem[i_addr] = (mem.exists(i_addr) ? mem[i_addr] : fill(i_addr)) & i_wdata;
  end
endmodule

`default_nettype wire

// ==== sfrb_flash_seq_bench.sv ====
// self-checking bench for the serial flash sequencer
// assumes sfrb_flash_seq, sfrb_arr_model and a 100 MHz core clock
`timescale 1ns/10ps
`include "sfrb_defs.svh"
`default_nettype none

module sfrb_flash_seq_bench;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic cs_n = 1'b1;
  logic sck = 1'b0;
  logic si = 1'b0;
  logic page_256 = 1'b0;
  logic so;
  logic so_oe;
  logic busy;
  logic arr_rd;
  logic arr_wr;
  logic arr_erase;
  logic [18:0] arr_addr;
  logic [7:0] arr_wdata;
  logic [7:0] arr_rdata;
  logic so_wire;
  logic [9:0] exp_pg = 10'h000;
  int n_fail = 0;
  int checks_done = 0;
  int n_wr = 0;
  int n_er = 0;
  int n_badpg = 0;

  always #5 i_clk = ~i_clk;
  assign so_wire = so_oe ? so : 1'bz;

  sfrb_flash_seq #(.P_FP_CYC(300), .P_PROG_CYC(300)) sfrb_flash_seq_i (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so), .o_so_oe(so_oe),
    .i_page_256(page_256), .o_busy(busy), .o_arr_rd(arr_rd), .o_arr_wr(arr_wr), .o_arr_erase(arr_erase),
    .o_arr_addr(arr_addr), .o_arr_wdata(arr_wdata), .i_arr_rdata(arr_rdata));

  sfrb_arr_model sfrb_arr_model_i (
    .i_clk(i_clk), .i_rd(arr_rd), .i_wr(arr_wr), .i_erase(arr_erase), .i_addr(arr_addr),
    .i_wdata(arr_wdata), .o_rdata(arr_rdata));

  // ****************************************
  // array port monitor
  // ****************************************
  always @(posedge i_clk)
  begin
    if (arr_wr)
      n_wr++;
    if (arr_erase)
      n_er++;
    if ((arr_wr || arr_erase) && arr_addr[18:9] !== exp_pg)
      n_badpg++;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] pat(input logic [18:0] a);
    return a[18] ? 8'hFF : (a[7:0] ^ a[16:9]);
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one byte each way, msb first; data changes on the falling edge
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge i_clk);
      sck <= 1'b0;
      si <= tx[i];
      repeat (8) @(posedge i_clk);
      rx[i] = so_wire;
      sck <= 1'b1;
      repeat (7) @(posedge i_clk);
    end
  endtask

  task automatic wr(input logic [7:0] tx);
    logic [7:0] rx;
    xbyte(tx, rx);
  endtask

  task automatic rd(input logic [7:0] exp);
    logic [7:0] rx;
    xbyte(8'h00, rx);
    check("so_byte", rx, exp);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] adr, input int dummies, input logic m3);
    @(posedge i_clk);
    sck <= m3;
    repeat (4) @(posedge i_clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    wr(op);
    wr(adr[23:16]);
    wr(adr[15:8]);
    wr(adr[7:0]);
    repeat (dummies) wr(8'h00);
  endtask

  task automatic cs_hi(input logic m3);
    @(posedge i_clk);
    sck <= m3;
    repeat (8) @(posedge i_clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    check("so_release", so_oe, 1'b0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_buf_wr;
    cmd(`SFRB_OP_BUF_WR, 24'h000106, 0, 1'b0);
    wr(8'hA1);
    wr(8'hA2);
    wr(8'hA3);
    wr(8'hA4);
    cs_hi(1'b0);
    check("buf_wr_strobes", n_wr + n_er, 0);
  endtask

  task automatic t_buf_rd;
    cmd(`SFRB_OP_BUF_RD_HF, 24'h7FFF06, 1, 1'b0);
    rd(8'hA1);
    rd(8'hA2);
    rd(8'hA3);
    rd(8'hA4);
    cs_hi(1'b0);
    cmd(`SFRB_OP_BUF_RD_LF, 24'h000000, 1, 1'b1);
    rd(8'hA3);
    rd(8'hA4);
    cs_hi(1'b1);
  endtask

  task automatic t_arr_rd;
    cmd(`SFRB_OP_ARR_RD_LF, {5'h00, 10'h005, 9'h106}, 0, 1'b0);
    rd(pat({10'h005, 9'h106}));
    rd(pat({10'h005, 9'h107}));
    rd(pat({10'h006, 9'h000}));
    cs_hi(1'b0);
    cmd(`SFRB_OP_ARR_RD_LF, {5'h00, 10'h3FF, 9'h107}, 0, 1'b0);
    rd(pat({10'h3FF, 9'h107}));
    rd(pat({10'h000, 9'h000}));
    cs_hi(1'b0);
  endtask

  task automatic t_page_rd;
    cmd(`SFRB_OP_PAGE_RD, {5'h00, 10'h007, 9'h107}, 4, 1'b0);
    rd(pat({10'h007, 9'h107}));
    rd(pat({10'h007, 9'h000}));
    cs_hi(1'b0);
    check("read_strobes", n_wr + n_er, 0);
  endtask

  task automatic t_bad_op;
    cmd(8'h5A, 24'h000106, 0, 1'b0);
    wr(8'hEE);
    cs_hi(1'b0);
    check("bad_op_strobes", n_wr + n_er, 0);
  endtask

  task automatic t_prog(input logic [7:0] op, input logic [9:0] pg, input int er_exp);
    int w0;
    int e0;
    int k;
    w0 = n_wr;
    e0 = n_er;
    exp_pg = pg;
    cmd(op, {5'h1F, pg, 9'h1FF}, 0, 1'b0);
    cs_hi(1'b0);
    check("busy_rise", busy, 1'b1);
    for (k = 0; k < 2000 && busy !== 1'b0; k++)
      @(posedge i_clk);
    check("busy_fall", busy, 1'b0);
    check("erase_count", n_er - e0, er_exp);
    check("write_count", n_wr - w0, 264);
    check("page_select", n_badpg, 0);
    cmd(`SFRB_OP_ARR_RD_LF, {5'h00, pg, 9'h000}, 0, 1'b0);
    rd(8'hA3);
    rd(8'hA4);
    cs_hi(1'b0);
  endtask

  task automatic t_256;
    @(posedge i_clk);
    page_256 <= 1'b1;
    repeat (10) @(posedge i_clk);
    cmd(`SFRB_OP_ARR_RD_LF, {6'h00, 10'h003, 8'hFF}, 0, 1'b0);
    rd(pat({10'h003, 1'b0, 8'hFF}));
    rd(pat({10'h004, 9'h000}));
    cs_hi(1'b0);
    cmd(`SFRB_OP_BUF_RD_HF, 24'h00FF01, 1, 1'b0);
    rd(8'hA4);
    cs_hi(1'b0);
    @(posedge i_clk);
    page_256 <= 1'b0;
    repeat (10) @(posedge i_clk);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_buf_wr();
    t_buf_rd();
    t_arr_rd();
    t_page_rd();
    t_bad_op();
    t_buf_rd();
    t_prog(`SFRB_OP_PROG_ERS, 10'h009, 1);
    t_prog(`SFRB_OP_PROG, 10'h258, 0);
    t_256();
    stop_test();
  end

  initial
  begin
    repeat (90000) @(posedge i_clk);
    n_fail++;
    stop_test();
  end
endmodule

`default_nettype wire
